// file: rtl/pci_bar_windows.sv
// PCI configuration base registers for the extension and CIS windows,
// with the matching memory window decode.
// Assumes a config port already decoded to this function, and memory
// requests presented one cycle each on the PCI clock.
`include "pci_bar_windows_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pci_bar_windows
    import pci_bar_windows_pkg::*;
#(
    parameter int CFG_ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    // Strap, sampled while reset is held
    input  wire logic                  i_card_mode_strap_n,
    // Configuration access port
    input  wire logic                  i_cfg_wr,
    input  wire logic                  i_cfg_rd,
    input  wire logic [CFG_ADDR_W-1:0] i_cfg_addr,
    input  wire logic [3:0]            i_cfg_be,
    input  wire logic [31:0]           i_cfg_wdata,
    output logic [31:0]                o_cfg_rdata,
    output logic                       o_cfg_rvalid,
    // Memory transaction decode
    input  wire logic                  i_mem_req,
    input  wire logic [31:0]           i_mem_addr,
    input  wire logic                  i_mem_space_en,
    output logic                       o_ext_hit,
    output logic                       o_cis_hit,
    // Window state for the rest of the function
    output logic                       o_cis_enabled,
    output logic [31:0]                o_ext_base,
    output logic [31:0]                o_card_info_window_pointer
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Offsets up to 18h need at least five address bits
    if (CFG_ADDR_W < 5 || CFG_ADDR_W > 8) begin : g_bad_addr_w
        $error("CFG_ADDR_W must lie between 5 and 8");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dword_t ext_base_r;
    dword_t ext_base_nxt;
    dword_t card_info_window_pointer_r;
    dword_t card_info_window_pointer_nxt;
    logic   cis_en_r;
    logic   cis_en_nxt;
    dword_t rdata_r;
    dword_t rdata_nxt;
    logic   rvalid_r;
    logic   rvalid_nxt;
    logic   ext_hit_r;
    logic   ext_hit_nxt;
    logic   cis_hit_r;
    logic   cis_hit_nxt;

    dword_t   lane_mask;
    logic [7:0] addr8;
    logic     sel_ext;
    logic     sel_cis;
    logic     cis_on;

    // Widen the config address so offsets compare at one width
    assign addr8   = 8'(i_cfg_addr);
    assign sel_ext = (addr8 & `CFG_DWORD_MASK) == `OFF_EXT_WINDOW_BASE;
    assign sel_cis = (addr8 & `CFG_DWORD_MASK) == `OFF_CIS_WINDOW_BASE;
    assign cis_on  = cis_en_r;

    // Byte enables to a bit mask, one lane per enable
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign lane_mask[8*g +: 8] = i_cfg_be[g] ? `BYTE_ONES : `BYTE_ZERO;
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Tracks the pin only while reset is held, then freezes
    // Kept in true polarity so the enable output needs no gate
    always_comb begin
        cis_en_nxt = cis_en_r;
        if (i_reset) begin
            cis_en_nxt = !i_card_mode_strap_n;
        end
    end

    // ------------------------------------------------------------------
    // Base registers
    // ------------------------------------------------------------------
    // Read-only bits never store, and readback still masks them again with the write masks
    always_comb begin
        ext_base_nxt = ext_base_r;
        card_info_window_pointer_nxt = card_info_window_pointer_r;
        if (i_cfg_wr && sel_ext) begin
            ext_base_nxt = (ext_base_r & ~(lane_mask & `EXT_WRITE_MASK))
                         | (i_cfg_wdata & lane_mask & `EXT_WRITE_MASK);
        end
        if (i_cfg_wr && sel_cis && cis_on) begin
            card_info_window_pointer_nxt = (card_info_window_pointer_r & ~(lane_mask & `CIS_WRITE_MASK))
                         | (i_cfg_wdata & lane_mask & `CIS_WRITE_MASK);
        end
        // Strap high keeps the register pinned at zero
        if (!cis_on) begin
            card_info_window_pointer_nxt = `BASE_RESET_VALUE;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets answer zero rather than stalling the access
    always_comb begin
        rvalid_nxt = i_cfg_rd;
        rdata_nxt  = `READ_ZERO;
        if (i_cfg_rd && sel_ext) begin
            rdata_nxt = ext_base_r & `EXT_WRITE_MASK;
        end else if (i_cfg_rd && sel_cis && cis_on) begin
            rdata_nxt = card_info_window_pointer_r & `CIS_WRITE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Memory decode
    // ------------------------------------------------------------------
    // An unprogrammed Card_info_window_pointer would alias address zero, so it never claims
    always_comb begin
        ext_hit_nxt = i_mem_req && i_mem_space_en
                   && ((i_mem_addr & `EXT_WRITE_MASK) == (ext_base_r & `EXT_WRITE_MASK));
        cis_hit_nxt = i_mem_req && i_mem_space_en && cis_on
                   && (card_info_window_pointer_r != `BASE_RESET_VALUE)
                   && ((i_mem_addr & `CIS_WRITE_MASK) == (card_info_window_pointer_r & `CIS_WRITE_MASK));
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Strap enable keeps tracking through reset, the rest clears
    always_ff @(posedge i_clk) begin
        cis_en_r <= cis_en_nxt;
        if (i_reset) begin
            ext_base_r <= `BASE_RESET_VALUE;
            card_info_window_pointer_r <= `BASE_RESET_VALUE;
            rdata_r    <= `READ_ZERO;
            rvalid_r   <= 1'b0;
            ext_hit_r  <= 1'b0;
            cis_hit_r  <= 1'b0;
        end else begin
            ext_base_r <= ext_base_nxt;
            card_info_window_pointer_r <= card_info_window_pointer_nxt;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
            ext_hit_r  <= ext_hit_nxt;
            cis_hit_r  <= cis_hit_nxt;
        end
    end

    // Outputs straight from flops
    assign o_cfg_rdata   = rdata_r;
    assign o_cfg_rvalid  = rvalid_r;
    assign o_ext_hit     = ext_hit_r;
    assign o_cis_hit     = cis_hit_r;
    assign o_cis_enabled = cis_en_r;
    assign o_ext_base    = ext_base_r;
    assign o_card_info_window_pointer    = card_info_window_pointer_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_ext_low_zero: assert property (
        (ext_base_r & ~`EXT_WRITE_MASK) == `READ_ZERO)
        else $error("extension base low bits not zero");

    chk_ext_flags_zero: assert property (
        o_cfg_rvalid |-> o_cfg_rdata[3:0] == 4'h0)
        else $error("read flag bits not zero");

    chk_ext_all_ones: assert property (
        (i_cfg_wr && sel_ext && i_cfg_be == 4'hf && i_cfg_wdata == 32'hffff_ffff)
        ##1 !i_cfg_wr ##1 (i_cfg_rd && sel_ext && !i_cfg_wr) |=> o_cfg_rdata == 32'hffff_c000)
        else $error("all-ones sizing readback wrong");

    chk_ext_ptr_write: assert property (
        (i_cfg_wr && sel_ext && i_cfg_be == 4'hf)
        |=> ext_base_r[31:14] == $past(i_cfg_wdata[31:14]))
        else $error("extension pointer not stored");

    chk_cis_off_zero: assert property (
        !cis_on |-> (card_info_window_pointer_r == `READ_ZERO && !o_cis_hit))
        else $error("CIS register alive with strap high");

    chk_cis_ptr_write: assert property (
        (i_cfg_wr && sel_cis && cis_on && i_cfg_be == 4'hf)
        |=> card_info_window_pointer_r[31:11] == $past(i_cfg_wdata[31:11]))
        else $error("CIS pointer not stored");

    chk_cis_low_zero: assert property (
        (card_info_window_pointer_r & ~`CIS_WRITE_MASK) == `READ_ZERO)
        else $error("Card_info_window_pointer low bits not zero");

    chk_cis_read_back: assert property (
        (i_cfg_rd && sel_cis) |=> o_cfg_rvalid && o_cfg_rdata[10:0] == 11'h000
            && o_cfg_rdata == $past(card_info_window_pointer_r))
        else $error("CIS readback wrong");

    chk_hit_needs_en: assert property (
        (o_ext_hit || o_cis_hit) |-> $past(i_mem_req) && $past(i_mem_space_en))
        else $error("window claimed without enabled request");

    chk_ext_hit_match: assert property (
        (i_mem_req && i_mem_space_en && i_mem_addr[31:14] == ext_base_r[31:14]) |=> o_ext_hit)
        else $error("extension window match not claimed");

endmodule

`default_nettype wire

// file: common/pci_bar_windows_defs.svh
// Constants for the two PCI memory window base registers.
// Assumes inclusion by bare name from the design files.
`ifndef PCI_BAR_WINDOWS_DEFS_SVH
`define PCI_BAR_WINDOWS_DEFS_SVH

// ----------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------
`define OFF_EXT_WINDOW_BASE   8'h14
`define OFF_CIS_WINDOW_BASE   8'h18
`define CFG_DWORD_MASK        8'hfc

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
// Pointer bits 31-14 writable, 13-0 read as zero (16K, mem, 32-bit, no prefetch)
`define EXT_WRITE_MASK        32'hffff_c000
// Pointer bits 31-11 writable, 10-0 read as zero (2K, mem, 32-bit, no prefetch)
`define CIS_WRITE_MASK        32'hffff_f800
`define BASE_RESET_VALUE      32'h0000_0000
`define READ_ZERO             32'h0000_0000
`define BYTE_ZERO             8'h00
`define BYTE_ONES             8'hff

`endif

// file: common/pci_bar_windows_pkg.sv
// Types shared by the window base register block.
// Assumes nothing of its surroundings.
`default_nettype none

package pci_bar_windows_pkg;
    typedef logic [31:0] dword_t;
    typedef logic [3:0]  byte_en_t;
endpackage

`default_nettype wire

// file: test/pci_host_model.sv
// Host model: configuration and memory address cycles.
// Assumes the window block answers one cycle after each strobe.
`timescale 1ns/1ps
`default_nettype none

module pci_host_model
    import pci_bar_windows_pkg::*;
(
    // Clock
    input  wire logic  i_clk,
    // Configuration cycles
    output logic       o_cfg_wr,
    output logic       o_cfg_rd,
    output logic [7:0] o_cfg_addr,
    output byte_en_t   o_cfg_be,
    output dword_t     o_cfg_wdata,
    input  wire dword_t i_cfg_rdata,
    input  wire logic  i_cfg_rvalid,
    // Memory address phases
    output logic       o_mem_req,
    output dword_t     o_mem_addr,
    output logic       o_mem_en,
    input  wire logic  i_ext_hit,
    input  wire logic  i_cis_hit
);
    // Idle bus at time zero
    initial begin
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_addr = 8'h00;
        o_cfg_be = 4'h0;
        o_cfg_wdata = 32'h0;
        o_mem_req = 1'b0;
        o_mem_addr = 32'h0;
        o_mem_en = 1'b0;
    end

    // Write; data inverted after the strobe so stale values never match
    task automatic cfg_write(input logic [7:0] addr, input byte_en_t be, input dword_t data);
        @(posedge i_clk);
        o_cfg_wr <= 1'b1;
        o_cfg_addr <= addr;
        o_cfg_be <= be;
        o_cfg_wdata <= data;
        @(posedge i_clk);
        o_cfg_wr <= 1'b0;
        o_cfg_wdata <= ~data;
    endtask

    // Read; unknown returned if the answer is not on time
    task automatic cfg_read(input logic [7:0] addr, output dword_t data);
        @(posedge i_clk);
        o_cfg_rd <= 1'b1;
        o_cfg_addr <= addr;
        @(posedge i_clk);
        o_cfg_rd <= 1'b0;
        #1;
        data = i_cfg_rvalid ? i_cfg_rdata : 32'hxxxx_xxxx;
    endtask

    // Address phase only; CIS data reached by single bytes
    task automatic mem_probe(input dword_t addr, input logic en, output logic [1:0] hits);
        @(posedge i_clk);
        o_mem_req <= 1'b1;
        o_mem_addr <= addr;
        o_mem_en <= en;
        @(posedge i_clk);
        o_mem_req <= 1'b0;
        o_mem_addr <= ~addr;
        #1;
        hits = {i_ext_hit, i_cis_hit};
    endtask
endmodule

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the window base registers.
// Assumes the host model drives every bus input.
`timescale 1ns/1ps
`default_nettype none
`include "pci_bar_windows_defs.svh"

module tb_top import pci_bar_windows_pkg::*;;
    logic       i_clk, i_reset, strap_n, cfg_wr, cfg_rd, mem_req, mem_en, rvalid, ext_hit, cis_hit, cis_en;
    logic [7:0] cfg_addr;
    byte_en_t   cfg_be;
    dword_t     cfg_wdata, rdata, mem_addr, ext_base, card_info_window_pointer, ext_m, cis_m, rd;
    logic [1:0] hits;
    logic [31:0] r;
    int         errors, samples_checked, seed;

    pci_bar_windows pci_bar_windows_inst (.i_clk(i_clk), .i_reset(i_reset), .i_card_mode_strap_n(strap_n),
        .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata),
        .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_mem_req(mem_req), .i_mem_addr(mem_addr),
        .i_mem_space_en(mem_en), .o_ext_hit(ext_hit), .o_cis_hit(cis_hit), .o_cis_enabled(cis_en),
        .o_ext_base(ext_base), .o_card_info_window_pointer(card_info_window_pointer));
    pci_host_model pci_host_model_inst (.i_clk(i_clk), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd), .o_cfg_addr(cfg_addr),
        .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid), .o_mem_req(mem_req),
        .o_mem_addr(mem_addr), .o_mem_en(mem_en), .i_ext_hit(ext_hit), .i_cis_hit(cis_hit));

    // Lane merge of writable bits only
    function automatic dword_t merge(dword_t old, byte_en_t be, dword_t d, dword_t m);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) old[8*i+:8] = d[8*i+:8] & m[8*i+:8];
        end
        return old;
    endfunction

    task automatic check(input string name, input dword_t seen, input dword_t exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One reset with the given strap, then sizing, random access and decode
    task automatic phase(input logic strap);
        logic [7:0] a;
        dword_t     d;
        @(posedge i_clk);
        i_reset <= 1'b1;
        strap_n <= strap;
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        check("cis_enabled", {31'h0, cis_en}, {31'h0, !strap});
        pci_host_model_inst.cfg_write(`OFF_EXT_WINDOW_BASE, 4'hf, 32'hffff_ffff);
        pci_host_model_inst.cfg_read(`OFF_EXT_WINDOW_BASE, rd);
        check("ext_sizing", rd, 32'hffff_c000);
        pci_host_model_inst.mem_probe(32'h0000_0100, 1'b1, hits);
        check("zero_base", {30'h0, hits}, 32'h0);
        pci_host_model_inst.cfg_write(`OFF_CIS_WINDOW_BASE, 4'hf, 32'hffff_ffff);
        pci_host_model_inst.cfg_read(`OFF_CIS_WINDOW_BASE, rd);
        cis_m = strap ? 32'h0 : 32'hffff_f800;
        check("cis_sizing", rd, cis_m);
        ext_m = 32'hffff_c000;
        repeat (40) begin
            r = $random(seed);
            a = (r[1:0] == 2'h0) ? 8'h1c : (r[2] ? `OFF_EXT_WINDOW_BASE : `OFF_CIS_WINDOW_BASE);
            d = $random(seed);
            pci_host_model_inst.cfg_write(a, r[7:4], d);
            if (a == 8'h14) ext_m = merge(ext_m, r[7:4], d, `EXT_WRITE_MASK);
            if (a == 8'h18 && !strap) cis_m = merge(cis_m, r[7:4], d, `CIS_WRITE_MASK);
            pci_host_model_inst.cfg_read(a, rd);
            check("cfg_read", rd, (a == 8'h14) ? ext_m : ((a == 8'h18) ? cis_m : 32'h0));
            check("ext_base", ext_base, ext_m);
            check("card_info_window_pointer", card_info_window_pointer, cis_m);
        end
        // Addresses inside each window, plus random misses
        repeat (30) begin
            r = $random(seed);
            d = r[0] ? {ext_m[31:14], r[13:0]} : (r[1] ? {cis_m[31:11], r[10:0]} : $random(seed));
            pci_host_model_inst.mem_probe(d, r[2], hits);
            check("hits", {30'h0, hits}, {30'h0, r[2] && d[31:14] == ext_m[31:14],
                r[2] && !strap && cis_m != 32'h0 && d[31:11] == cis_m[31:11]});
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Strap low, then high after a mid-run reset, then low again
    initial begin
        seed = 32'h5a76a418;
        errors = 0;
        samples_checked = 0;
        i_reset <= 1'b1;
        strap_n <= 1'b0;
        phase(1'b0);
        phase(1'b1);
        phase(1'b0);
        end_sim();
    end

    // Run needs well under ten thousand cycles
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
